// ==== hw/sfc_pkg.sv ====
// sfc_pkg: shared constants and carrier types of the supply fault conditioner
// assumes: included first; no other package needed
package sfc_pkg;
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned FILT_MAX_US    = 100;
   localparam int unsigned FILT_MAX_CYC   = FILT_MAX_US * CLK_MHZ;
   localparam int unsigned PULSE_MAX_US   = 100;
   localparam int unsigned PULSE_MAX_CYC  = PULSE_MAX_US * CLK_MHZ;
   localparam int unsigned N_CHAN         = 10;
   localparam int unsigned N_DED          = 5;
   localparam int unsigned N_DUAL         = 5;
   localparam int unsigned THR_W          = 8;
   localparam int unsigned HYS_W          = 5;
   localparam int unsigned CNT_W          = 14;
   localparam int unsigned CODE_FULL      = 255;
   localparam logic [4:0]  HYS_MAX        = 5'h1f;
   localparam logic [CNT_W-1:0] CNT_RST   = 14'h0000;
   localparam logic [THR_W-1:0] CODE_RST  = 8'h00;
   localparam int unsigned HV_IDX         = 0;
   localparam int unsigned FIRST_POS_IDX  = 1;

   typedef enum logic [1:0] {
      SFC_MODE_UV  = 2'b00,
      SFC_MODE_OV  = 2'b01,
      SFC_MODE_WIN = 2'b10,
      SFC_MODE_OFF = 2'b11
   } sfc_mode_e;

   typedef enum logic [1:0] {
      SFC_RNG_LOW  = 2'b00,
      SFC_RNG_MID  = 2'b01,
      SFC_RNG_HIGH = 2'b10,
      SFC_RNG_TOP  = 2'b11
   } sfc_range_e;

   // one detector's settings; thresholds are codes on the range scale
   typedef struct packed {
      sfc_mode_e        mode;
      sfc_range_e       range;
      logic [THR_W-1:0] uv_code;
      logic [THR_W-1:0] ov_code;
      logic [HYS_W-1:0] hys_code;
      logic [CNT_W-1:0] filt_cyc;
   } sfc_det_cfg_s;

   // logic-input settings of a dual channel
   typedef struct packed {
      logic             use_logic;
      logic             edge_mode;
      logic [CNT_W-1:0] pulse_cyc;
   } sfc_dig_cfg_s;
endpackage

// ==== hw/sfc_glitch_filter.sv ====
// sfc_glitch_filter: passes a level only once it has held for filt_cyc
// assumes: input is synchronous to clk_sys_in
`timescale 1ns/1ps
module sfc_glitch_filter
   import sfc_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   // data
   input  wire logic [CNT_W-1:0] filt_cyc_in,
   input  wire logic             raw_in,
   output logic                  filt_out
);
   import sfc_pkg::*;
   logic [CNT_W-1:0] cnt_reg;

   // count how long the raw level differs from the output; a pulse
   // shorter than the timeout is dropped, a longer one shows after it
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         cnt_reg  <= CNT_RST;
         filt_out <= 1'b0;
      end else if (raw_in == filt_out) begin
         cnt_reg <= CNT_RST;
      end else if (cnt_reg + 14'h0001 >= filt_cyc_in) begin
         cnt_reg  <= CNT_RST;
         filt_out <= raw_in;
      end else begin
         cnt_reg <= cnt_reg + 14'h0001;
      end
   end
endmodule

// ==== hw/sfc_detector.sv ====
// sfc_detector: one threshold detector with hysteresis and glitch filter
// assumes: level codes come from a converter already scaled to the range
`timescale 1ns/1ps
module sfc_detector
   import sfc_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   // settings and input
   input  wire sfc_det_cfg_s     cfg_in,
   input  wire logic             enable_in,
   input  wire logic [THR_W-1:0] level_in,
   // result
   output logic                  fault_out
);
   import sfc_pkg::*;
   logic       uv_reg;
   logic       ov_reg;
   logic       raw;
   logic [8:0] uv_release;
   logic [8:0] ov_release;

   // release points widened by one bit so uv_release cannot wrap; an ov_release wrap is caught below
   assign uv_release = {1'b0, cfg_in.uv_code} + {4'h0, cfg_in.hys_code};
   assign ov_release = {1'b0, cfg_in.ov_code} - {4'h0, cfg_in.hys_code};

   // compare every cycle; hysteresis only widens the clear point
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in || !enable_in) begin
         uv_reg <= 1'b0;
         ov_reg <= 1'b0;
      end else begin
         if (!uv_reg)
            uv_reg <= (level_in < cfg_in.uv_code);
         else
            uv_reg <= ({1'b0, level_in} <= uv_release);
         if (!ov_reg)
            ov_reg <= (level_in > cfg_in.ov_code);
         else if (cfg_in.ov_code < {3'h0, cfg_in.hys_code})
            ov_reg <= 1'b1; // release point below code zero
         else
            ov_reg <= ({1'b0, level_in} >= ov_release);
      end
   end

   // fault kind selection
   always_comb begin
      case (cfg_in.mode)
         SFC_MODE_UV:  raw = uv_reg;
         SFC_MODE_OV:  raw = ov_reg;
         SFC_MODE_WIN: raw = uv_reg | ov_reg;
         default:      raw = 1'b0;
      endcase
   end

   sfc_glitch_filter u_filt (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in & enable_in), // disabled: no stale fault
      .filt_cyc_in (cfg_in.filt_cyc),
      .raw_in      (raw),
      .filt_out    (fault_out)
   );
endmodule

// ==== hw/sfc_top.sv ====
// sfc_top: ten-channel supply fault and logic input conditioner
// assumes: comparator levels arrive as 8-bit codes on the range scale,
// already scaled so the code compares directly against threshold codes;
// logic pins are asynchronous and synchronised here
// Overview of operation
// - ten channels: five dedicated detectors, five dual-function inputs.
// - a dual channel is either analog detector or logic input.
// - detector flags undervoltage, overvoltage or out-of-window.
// - each threshold is an 8-bit code, step of span over 255.
// - threshold equals span times code over 255 plus range bottom.
// - four ranges; high channel upper two, positive lower three.
// - dual-function analog detectors use only the lowest range.
// - comparisons evaluated every cycle on enabled channels.
// - hysteresis applies after a fault, widening the clear point.
// - hysteresis is a 5-bit code, maximum 31.
// - every detector output passes a glitch filter up to 100 us.
// - filter drops short pulses, passes long ones, delays by timeout.
// - logic-mode dual detectors become warning detectors on dedicated.
// - a warning detector uses the range of its shared channel.
// - warnings readable as status and ORed into one signal.
// - level mode outputs a buffered copy of the logic input.
// - edge mode emits one pulse of programmable width.
// - logic inputs use the same glitch filter.
// - conditioned logic outputs go to the sequencing engine.
// - sequencing engine sees the filtered fault outputs.
`timescale 1ns/1ps
module sfc_top
   import sfc_pkg::*;
(
   // clock and reset
   input  wire logic                         clk_sys_in,
   input  wire logic                         rst_b_in,
   // dedicated channel settings: index 0 high voltage, 1..4 positive
   input  wire sfc_det_cfg_s [N_DED-1:0]     ded_cfg_in,
   input  wire logic [N_DED-1:0]             ded_enable_in,
   input  wire logic [N_DED-1:0][THR_W-1:0]  ded_level_in,
   // dual channel settings; analog setting doubles as warning setting
   input  wire sfc_det_cfg_s [N_DUAL-1:0]    dual_cfg_in,
   input  wire sfc_dig_cfg_s [N_DUAL-1:0]    dual_dig_cfg_in,
   input  wire logic [N_DUAL-1:0]            dual_enable_in,
   input  wire logic [N_DUAL-1:0][THR_W-1:0] dual_level_in,
   // secondary levels seen on the dedicated pins for the warning detectors
   input  wire logic [N_DUAL-1:0][THR_W-1:0] warn_level_in,
   // logic pins of the dual-function inputs, asynchronous
   input  wire logic [N_DUAL-1:0]            dual_function_input_in,
   // results to the sequencing engine and status readback
   output logic [N_CHAN-1:0]                 channel_fault_out,
   output logic [N_DUAL-1:0]                 warning_status_out,
   output logic                              warning_any_out,
   output logic [N_DUAL-1:0]                 logic_input_out,
   output logic [N_DED-1:0]                  cfg_error_out
);
   import sfc_pkg::*;

   logic [N_DED-1:0]  ded_fault;
   logic [N_DUAL-1:0] dual_fault;
   logic [N_DUAL-1:0] warn_fault;
   logic [N_DUAL-1:0] sync1_reg;
   logic [N_DUAL-1:0] sync2_reg;
   logic [N_DUAL-1:0] dig_filt;
   logic [N_DUAL-1:0] dig_prev_reg;
   logic [N_DUAL-1:0] pulse_active_reg;
   logic [N_DUAL-1:0] logic_next;
   logic [N_DUAL-1:0][CNT_W-1:0] pulse_cnt_reg;
   sfc_det_cfg_s [N_DED-1:0]  ded_cfg_eff;
   sfc_det_cfg_s [N_DUAL-1:0] dual_cfg_eff;
   sfc_det_cfg_s [N_DUAL-1:0] warn_cfg_eff;

   // which dedicated channel a dual channel's warning detector shares
   function automatic int unsigned warn_host(input int unsigned idx);
      if (idx == N_DUAL - 1)
         return HV_IDX; // fifth dual maps to the high voltage input
      else
         return idx + FIRST_POS_IDX;
   endfunction

   // is a range legal for a channel kind; 0 high, 1 positive, 2 dual
   function automatic logic range_ok(input logic [1:0] kind,
                                     input sfc_range_e rng);
      case (kind)
         2'h0:    return (rng == SFC_RNG_HIGH) || (rng == SFC_RNG_TOP);
         2'h1:    return rng != SFC_RNG_TOP;
         default: return rng == SFC_RNG_LOW;
      endcase
   endfunction

   // clamp hysteresis to the 5-bit maximum
   function automatic logic [HYS_W-1:0] hys_clamp(input logic [HYS_W-1:0] h);
      return (h > HYS_MAX) ? HYS_MAX : h;
   endfunction

   // clamp a filter or pulse length to its 100 us ceiling
   function automatic logic [CNT_W-1:0] cyc_clamp(input logic [CNT_W-1:0] c);
      return (c > CNT_W'(FILT_MAX_CYC)) ? CNT_W'(FILT_MAX_CYC) : c;
   endfunction

   // effective settings: illegal dedicated ranges fall back to a legal one and are
   // flagged, since a wrong scale would place thresholds nowhere sensible
   genvar gi;
   generate
      for (gi = 0; gi < N_DED; gi++) begin : g_ded
         always_comb begin
            ded_cfg_eff[gi]          = ded_cfg_in[gi];
            ded_cfg_eff[gi].hys_code = hys_clamp(ded_cfg_in[gi].hys_code);
            ded_cfg_eff[gi].filt_cyc = cyc_clamp(ded_cfg_in[gi].filt_cyc);
            if (!range_ok((gi == HV_IDX) ? 2'h0 : 2'h1,
                          ded_cfg_in[gi].range)) begin
               ded_cfg_eff[gi].range =
                  (gi == HV_IDX) ? SFC_RNG_HIGH : SFC_RNG_LOW;
            end
         end

         // flag a bad range as a register so readback is stable
         always_ff @(posedge clk_sys_in) begin
            if (!rst_b_in)
               cfg_error_out[gi] <= 1'b0;
            else
               cfg_error_out[gi] <= !range_ok((gi == HV_IDX) ? 2'h0 : 2'h1,
                                              ded_cfg_in[gi].range);
         end

         // threshold codes compare on the range scale
         sfc_detector u_ded (
            .clk_sys_in (clk_sys_in),
            .rst_b_in   (rst_b_in),
            .cfg_in     (ded_cfg_eff[gi]),
            .enable_in  (ded_enable_in[gi]),
            .level_in   (ded_level_in[gi]),
            .fault_out  (ded_fault[gi])
         );
      end

      for (gi = 0; gi < N_DUAL; gi++) begin : g_dual
         // dual analog detector pinned to the lowest range
         always_comb begin
            dual_cfg_eff[gi]          = dual_cfg_in[gi];
            dual_cfg_eff[gi].range    = SFC_RNG_LOW;
            dual_cfg_eff[gi].hys_code = hys_clamp(dual_cfg_in[gi].hys_code);
            dual_cfg_eff[gi].filt_cyc = cyc_clamp(dual_cfg_in[gi].filt_cyc);
            warn_cfg_eff[gi]          = dual_cfg_eff[gi];
            warn_cfg_eff[gi].range    =
               ded_cfg_eff[warn_host(gi)].range;
         end

         // analog use only when not a logic input
         sfc_detector u_dual (
            .clk_sys_in (clk_sys_in),
            .rst_b_in   (rst_b_in),
            .cfg_in     (dual_cfg_eff[gi]),
            .enable_in  (dual_enable_in[gi] &
                         !dual_dig_cfg_in[gi].use_logic),
            .level_in   (dual_level_in[gi]),
            .fault_out  (dual_fault[gi])
         );

         // the same detector reused as warning on the dedicated input
         sfc_detector u_warn (
            .clk_sys_in (clk_sys_in),
            .rst_b_in   (rst_b_in),
            .cfg_in     (warn_cfg_eff[gi]),
            .enable_in  (dual_enable_in[gi] &
                         dual_dig_cfg_in[gi].use_logic),
            .level_in   (warn_level_in[gi]),
            .fault_out  (warn_fault[gi])
         );

         // logic path shares the detector's glitch filter design
         sfc_glitch_filter u_dig_filt (
            .clk_sys_in  (clk_sys_in),
            .rst_b_in    (rst_b_in),
            .filt_cyc_in (dual_cfg_eff[gi].filt_cyc),
            .raw_in      (sync2_reg[gi]),
            .filt_out    (dig_filt[gi])
         );

         // level copy or edge pulse; a zero width gives no pulse
         always_comb begin
            if (!dual_dig_cfg_in[gi].use_logic)
               logic_next[gi] = 1'b0;
            else if (!dual_dig_cfg_in[gi].edge_mode)
               logic_next[gi] = dig_filt[gi];
            else
               logic_next[gi] = pulse_active_reg[gi];
         end

         // pulse timer, restarted by each filtered transition
         always_ff @(posedge clk_sys_in) begin
            if (!rst_b_in) begin
               pulse_active_reg[gi] <= 1'b0;
               pulse_cnt_reg[gi]    <= CNT_RST;
            end else if (dig_filt[gi] != dig_prev_reg[gi] &&
                         cyc_clamp(dual_dig_cfg_in[gi].pulse_cyc)
                         != CNT_RST) begin
               pulse_active_reg[gi] <= 1'b1;
               pulse_cnt_reg[gi]    <=
                  cyc_clamp(dual_dig_cfg_in[gi].pulse_cyc) - 14'h0001;
            end else if (pulse_cnt_reg[gi] != CNT_RST) begin
               pulse_cnt_reg[gi] <= pulse_cnt_reg[gi] - 14'h0001;
            end else begin
               pulse_active_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // two-flop synchroniser on the logic pins, then edge history
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         sync1_reg    <= 5'h00;
         sync2_reg    <= 5'h00;
         dig_prev_reg <= 5'h00;
      end else begin
         sync1_reg    <= dual_function_input_in;
         sync2_reg    <= sync1_reg;
         dig_prev_reg <= dig_filt;
      end
   end

   // registered results; a dual channel in logic mode reports no fault
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         channel_fault_out  <= 10'h000;
         warning_status_out <= 5'h00;
         warning_any_out    <= 1'b0;
         logic_input_out    <= 5'h00;
      end else begin
         channel_fault_out  <= {dual_fault, ded_fault};
         warning_status_out <= warn_fault;
         warning_any_out    <= |warn_fault;
         logic_input_out    <= logic_next;
      end
   end

   // the first positive filter choice is software's concern

   AST_WARN_OR: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      warning_any_out == |warning_status_out)
      else $error("warning summary differs from status");
   AST_FAULT_REG: assert property (@(posedge clk_sys_in)
      disable iff (!rst_b_in)
      ##1 channel_fault_out == $past({dual_fault, ded_fault}))
      else $error("channel fault not the filtered result");
   AST_EXCL: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      dual_dig_cfg_in[3].use_logic [*3] |-> !channel_fault_out[8])
      else $error("logic channel shows an analog fault");
   AST_LEVEL: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (dual_dig_cfg_in[1].use_logic && !dual_dig_cfg_in[1].edge_mode)
      |=> logic_input_out[1] == $past(dig_filt[1]))
      else $error("level mode output not a copy");
   AST_EDGE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      (dual_dig_cfg_in[2].use_logic && dual_dig_cfg_in[2].edge_mode &&
       $stable(dual_dig_cfg_in[2]) && $rose(dig_filt[2]) &&
       dual_dig_cfg_in[2].pulse_cyc != CNT_RST)
      |-> ##2 logic_input_out[2])
      else $error("edge produced no pulse");
   AST_NOWARN: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      !dual_dig_cfg_in[1].use_logic [*3] |-> !warning_status_out[1])
      else $error("warning from an analog dual channel");
   AST_SYNC: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ##2 sync2_reg == $past(dual_function_input_in, 2))
      else $error("logic pin not synchronised in two stages");
   AST_RANGE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ded_cfg_in[0].range == SFC_RNG_LOW |=> cfg_error_out[0])
      else $error("bad high voltage range not flagged");
   AST_HYS: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ded_cfg_eff[1].hys_code <= HYS_MAX)
      else $error("hysteresis above maximum");

   COV_FAULT: cover property (@(posedge clk_sys_in) $rose(channel_fault_out[1]));
   COV_WARN:  cover property (@(posedge clk_sys_in) $rose(warning_any_out));
   COV_PULSE: cover property (@(posedge clk_sys_in) $rose(logic_input_out[2]));
endmodule

// ==== testbench/sfc_rail_model.sv ====
// sfc_rail_model: the monitored rails and external logic pins
// assumes: the bench calls its tasks; every change lands on a clock edge
`timescale 1ns/1ps
module sfc_rail_model
   import sfc_pkg::*;
(
   // clock
   input  wire logic                    clk_sys_in,
   // rail codes and logic pins seen by the conditioner
   output logic [N_DED-1:0][THR_W-1:0]  ded_level_out,
   output logic [N_DUAL-1:0][THR_W-1:0] dual_level_out,
   output logic [N_DUAL-1:0][THR_W-1:0] warn_level_out,
   output logic [N_DUAL-1:0]            pin_out
);
   // rails idle mid-scale so no detector starts out in fault
   initial begin
      ded_level_out = {N_DED{8'h80}};
      dual_level_out = {N_DUAL{8'h80}};
      warn_level_out = {N_DUAL{8'h80}};
      pin_out = 5'h00;
   end
   // a rail moves and then sits at its new level: 0 ded, 1 dual, 2 warn
   task automatic set_rail(input int unsigned g, input int unsigned i,
                           input logic [THR_W-1:0] code);
      @(posedge clk_sys_in);
      case (g)
         0: ded_level_out[i] <= code;
         1: dual_level_out[i] <= code;
         default: warn_level_out[i] <= code;
      endcase
   endtask
   // supply bounce: a dedicated rail dips for n cycles, then recovers
   task automatic dip_rail(input int unsigned i, input logic [THR_W-1:0] code,
                           input int unsigned n);
      logic [THR_W-1:0] keep;
      keep = ded_level_out[i];
      @(posedge clk_sys_in);
      ded_level_out[i] <= code;
      repeat (n) @(posedge clk_sys_in);
      ded_level_out[i] <= keep;
   endtask
   // logic pin driven by an external reset source or switch
   task automatic set_pin(input int unsigned i, input logic lvl);
      @(posedge clk_sys_in);
      pin_out[i] <= lvl;
   endtask
   // switch bounce: a pin pulses high for n cycles only
   task automatic bounce_pin(input int unsigned i, input int unsigned n);
      set_pin(i, 1'b1);
      repeat (n) @(posedge clk_sys_in);
      pin_out[i] <= 1'b0;
   endtask
endmodule

// ==== testbench/sfc_top_tb_top.sv ====
// sfc_top_tb_top: self-checking bench of the supply fault conditioner
// assumes: sfc_rail_model plays the rails; filters run with 3 cycles
`timescale 1ns/1ps
module sfc_top_tb_top;
   import sfc_pkg::*;
   // short filter keeps the run brief; nonzero on every channel
   localparam logic [CNT_W-1:0] FILT = 14'h0003;
   logic                              clk_sys;
   logic                              rst_b;
   sfc_det_cfg_s [N_DED-1:0]          ded_cfg;
   sfc_det_cfg_s [N_DUAL-1:0]         dual_cfg;
   sfc_dig_cfg_s [N_DUAL-1:0]         dual_dig;
   logic [N_DED-1:0]                  ded_en;
   logic [N_DUAL-1:0]                 dual_en;
   logic [N_DED-1:0][THR_W-1:0]       ded_lvl;
   logic [N_DUAL-1:0][THR_W-1:0]      dual_lvl;
   logic [N_DUAL-1:0][THR_W-1:0]      warn_lvl;
   logic [N_DUAL-1:0]                 pins;
   logic [N_CHAN-1:0]                 fault;
   logic [N_DUAL-1:0]                 warn;
   logic                              warn_any;
   logic [N_DUAL-1:0]                 logic_o;
   logic [N_DED-1:0]                  cfg_err;
   wire logic [19:0]                  obs;
   int                                n_fail = 0;
   int                                total_checks = 0;
   // one view: faults 0..9, warnings 10..14, logic outputs 15..19
   assign obs = {logic_o, warn, fault};
   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;
   sfc_rail_model sfc_rail_model_inst (.clk_sys_in(clk_sys),
      .ded_level_out(ded_lvl), .dual_level_out(dual_lvl),
      .warn_level_out(warn_lvl), .pin_out(pins));
   sfc_top sfc_top_inst (.clk_sys_in(clk_sys), .rst_b_in(rst_b),
      .ded_cfg_in(ded_cfg), .ded_enable_in(ded_en), .ded_level_in(ded_lvl),
      .dual_cfg_in(dual_cfg), .dual_dig_cfg_in(dual_dig),
      .dual_enable_in(dual_en), .dual_level_in(dual_lvl),
      .warn_level_in(warn_lvl), .dual_function_input_in(pins),
      .channel_fault_out(fault), .warning_status_out(warn),
      .warning_any_out(warn_any), .logic_input_out(logic_o),
      .cfg_error_out(cfg_err));
   // compare helpers, one per kind of result
   task automatic chk_bit(input logic got, input logic exp, input string s);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s: got %b want %b", $time, s, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [9:0] got, input logic [9:0] exp,
                          input string s);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s: got %h want %h", $time, s, got, exp);
      end
   endtask
   task automatic tick(input int unsigned n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // settings always carry the nonzero filter
   function automatic sfc_det_cfg_s mk(input sfc_mode_e m, input sfc_range_e r,
      input logic [7:0] uv, input logic [7:0] ov, input logic [4:0] hy);
      mk = '{mode: m, range: r, uv_code: uv, ov_code: ov, hys_code: hy,
             filt_cyc: FILT};
   endfunction
   task automatic set_cfg(input logic dual, input int unsigned i,
                          input sfc_det_cfg_s c);
      @(posedge clk_sys);
      if (dual) dual_cfg[i] <= c;
      else ded_cfg[i] <= c;
      tick(4);
   endtask
   task automatic set_dig(input int unsigned i, input sfc_dig_cfg_s c);
      @(posedge clk_sys);
      dual_dig[i] <= c;
      tick(4);
   endtask
   // move a rail, let the filter settle, then look at one output bit
   task automatic step(input int unsigned g, input int unsigned i,
      input logic [7:0] code, input int unsigned b, input logic exp,
      input string s);
      sfc_rail_model_inst.set_rail(g, i, code);
      tick(8);
      chk_bit(obs[b], exp, s);
   endtask
   task automatic watch(input int unsigned b, input int unsigned n,
                        output logic seen);
      seen = 1'b0;
      repeat (n) begin
         tick(1);
         seen = seen | obs[b];
      end
   endtask
   task automatic t_uv;
      set_cfg(1'b0, 1, mk(SFC_MODE_UV, SFC_RNG_MID, 8'h80, 8'hff, 5'h04));
      chk_bit(fault[1], 1'b0, "level at threshold");
      sfc_rail_model_inst.set_rail(0, 1, 8'h7f);
      tick(3);
      chk_bit(fault[1], 1'b0, "fault held by filter");
      tick(4);
      chk_bit(fault[1], 1'b1, "undervoltage");
      step(0, 1, 8'h84, 1, 1'b1, "inside hysteresis");
      step(0, 1, 8'h85, 1, 1'b0, "above hysteresis");
      step(0, 1, 8'h10, 1, 1'b1, "deep undervoltage");
      @(posedge clk_sys);
      ded_en[1] <= 1'b0;
      tick(8);
      chk_bit(fault[1], 1'b0, "disabled channel");
      @(posedge clk_sys);
      ded_en[1] <= 1'b1;
      step(0, 1, 8'h85, 1, 1'b0, "recovered");
      $display("test undervoltage done");
   endtask
   task automatic t_ov_win;
      set_cfg(1'b0, 2, mk(SFC_MODE_OV, SFC_RNG_MID, 8'h00, 8'hb6, 5'h04));
      step(0, 2, 8'hb6, 2, 1'b0, "at ov threshold");
      step(0, 2, 8'hb7, 2, 1'b1, "overvoltage");
      step(0, 2, 8'hb2, 2, 1'b1, "inside hysteresis");
      step(0, 2, 8'hb1, 2, 1'b0, "below hysteresis");
      set_cfg(1'b0, 3, mk(SFC_MODE_WIN, SFC_RNG_MID, 8'h40, 8'hc0, 5'h00));
      step(0, 3, 8'h3f, 3, 1'b1, "window low");
      step(0, 3, 8'h80, 3, 1'b0, "window inside");
      step(0, 3, 8'hc1, 3, 1'b1, "window high");
      step(0, 3, 8'h80, 3, 1'b0, "window back");
      set_cfg(1'b0, 2, mk(SFC_MODE_OFF, SFC_RNG_MID, 8'h80, 8'h10, 5'h00));
      step(0, 2, 8'hff, 2, 1'b0, "detector off");
      $display("test overvoltage and window done");
   endtask
   task automatic t_glitch;
      logic seen;
      set_cfg(1'b0, 4, mk(SFC_MODE_UV, SFC_RNG_MID, 8'h70, 8'hff, 5'h00));
      sfc_rail_model_inst.dip_rail(4, 8'h10, 2);
      watch(4, 12, seen);
      chk_bit(seen, 1'b0, "short dip dropped");
      sfc_rail_model_inst.dip_rail(4, 8'h10, 6);
      watch(4, 12, seen);
      chk_bit(seen, 1'b1, "long dip passed");
      $display("test glitch filter done");
   endtask
   task automatic t_dual;
      set_cfg(1'b1, 0, mk(SFC_MODE_UV, SFC_RNG_LOW, 8'h40, 8'hff, 5'h00));
      sfc_rail_model_inst.set_pin(0, 1'b1);
      step(1, 0, 8'h30, 5, 1'b1, "dual analog fault");
      chk_bit(logic_o[0], 1'b0, "analog pin not logic");
      step(1, 0, 8'h80, 5, 1'b0, "dual analog clear");
      $display("test dual analog done");
   endtask
   task automatic t_logic;
      logic seen;
      set_dig(1, '{use_logic: 1'b1, edge_mode: 1'b0, pulse_cyc: 14'h0000});
      sfc_rail_model_inst.bounce_pin(1, 2);
      watch(16, 12, seen);
      chk_bit(seen, 1'b0, "bounce ignored");
      sfc_rail_model_inst.set_pin(1, 1'b1);
      tick(10);
      chk_bit(logic_o[1], 1'b1, "level copy high");
      sfc_rail_model_inst.set_pin(1, 1'b0);
      tick(10);
      chk_bit(logic_o[1], 1'b0, "level copy low");
      $display("test logic level done");
   endtask
   task automatic t_edge;
      int unsigned width;
      int unsigned rises;
      logic prev;
      set_dig(2, '{use_logic: 1'b1, edge_mode: 1'b1, pulse_cyc: 14'h0006});
      for (int k = 0; k < 2; k++) begin
         width = 0;
         rises = 0;
         prev = 1'b0;
         sfc_rail_model_inst.set_pin(2, k == 0);
         repeat (30) begin
            tick(1);
            if (logic_o[2] === 1'b1 && prev !== 1'b1) rises++;
            if (logic_o[2] === 1'b1) width++;
            prev = logic_o[2];
         end
         chk_vec(10'(width), 10'h006, "pulse width");
         chk_vec(10'(rises), 10'h001, "one pulse per edge");
      end
      $display("test logic edge done");
   endtask
   task automatic t_warn;
      for (int j = 3; j < 5; j++) begin
         set_dig(j, '{use_logic: 1'b1, edge_mode: 1'b0, pulse_cyc: 14'h0000});
         set_cfg(1'b1, j, mk(SFC_MODE_UV, SFC_RNG_LOW, 8'h60, 8'hff, 5'h00));
         step(2, j, 8'h50, 10 + j, 1'b1, "warning set");
         chk_bit(warn_any, 1'b1, "warning or");
         chk_bit(fault[5+j], 1'b0, "no fault in logic mode");
         step(2, j, 8'h80, 10 + j, 1'b0, "warning clear");
         chk_bit(warn_any, 1'b0, "warning or clear");
      end
      $display("test warnings done");
   endtask
   task automatic t_cfg_err;
      set_cfg(1'b0, 0, mk(SFC_MODE_OFF, SFC_RNG_LOW, 8'h80, 8'hff, 5'h00));
      set_cfg(1'b0, 1, mk(SFC_MODE_OFF, SFC_RNG_TOP, 8'h80, 8'hff, 5'h00));
      chk_vec(10'(cfg_err), 10'h003, "illegal ranges flagged");
      set_cfg(1'b0, 0, mk(SFC_MODE_OFF, SFC_RNG_TOP, 8'h80, 8'hff, 5'h00));
      set_cfg(1'b0, 1, mk(SFC_MODE_OFF, SFC_RNG_LOW, 8'h80, 8'hff, 5'h00));
      chk_vec(10'(cfg_err), 10'h000, "legal ranges clean");
      $display("test range legality done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // main sequence: quiet settings, reset, then the scenarios
   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      ded_en = 5'h1f;
      dual_en = 5'h1f;
      for (int i = 0; i < N_DUAL; i++) begin
         ded_cfg[i] = mk(SFC_MODE_OFF, (i == 0) ? SFC_RNG_HIGH : SFC_RNG_MID,
                         8'h80, 8'hff, 5'h00);
         dual_cfg[i] = mk(SFC_MODE_OFF, SFC_RNG_LOW, 8'h80, 8'hff, 5'h00);
         dual_dig[i] = '{use_logic: 1'b0, edge_mode: 1'b0, pulse_cyc: 14'h0};
      end
      tick(5);
      chk_vec(fault, 10'h000, "faults quiet in reset");
      chk_vec({cfg_err, logic_o}, 10'h000, "outputs quiet");
      @(posedge clk_sys);
      rst_b <= 1'b1;
      tick(2);
      t_uv();
      t_ov_win();
      t_glitch();
      t_dual();
      t_logic();
      t_edge();
      t_warn();
      t_cfg_err();
      wrap_up();
   end
   // watchdog: the run needs well under 2000 cycles
   initial begin
      #200000;
      n_fail++;
      $display("ERROR %0t watchdog expired", $time);
      wrap_up();
   end
endmodule
